// ===== logic/bus_ready_idle.v
// Purpose: Ready sampling, wait-state and idle-state control of a bus interface unit
// Assumes: clk_sys_i is twice the bus clock rate; bus_clock_output is made by division
// Notes: Each T-state is two system clocks: phase 1 (output low) then phase 2 (high)
//
// Behaviour
// - Async ready sampled on phase 2 edge, then again with first stage on phase 1.
// - Async path ready only if active before both phase 2 and phase 1 edges.
// - Async path not ready if inactive before either edge.
// - Sync ready taken by one stage on the phase 1 edge.
// - Sync path ready exactly when sync ready was active before phase 1 edge.
// - Idle states only between bus cycles, for any length.
// - Idle on full queue, address calculation, inta/lock idle, halt or wait.
// - Idle after read floats the address/data bus.
// - Idle after write keeps driving the address/data bus.
// - Strobes inactive throughout idle; ALE for the next cycle is raised only in T1.
// - Four cycle kinds: read, write, interrupt acknowledge, halt.
// - I/O read puts port on low sixteen bits, upper four bits zero.
// - Prefetch is started by a request like other cycles and loads read data into the queue.
// - Memory read uses all twenty address bits.
// - T-state spans falling edge to falling edge; low half phase 1.
// - Ready if either input ready; not ready only when both inactive.
// - Wait states after T3, before T4, repeating until ready.
`timescale 1ns/100ps
`include "bus_ready_defs.vh"

module bus_ready_idle #(
  parameter ADDR_W = `ADDR_W
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire ce_i,
  input wire async_ready_in_i,
  input wire sync_ready_in_i,
  input wire req_valid_i,
  input wire [2:0] req_status_i,
  input wire [ADDR_W-1:0] req_addr_i,
  input wire [15:0] req_wdata_i,
  input wire queue_full_i,
  input wire ea_calc_i,
  input wire lock_idle_i,
  input wire halt_wait_i,
  input wire [15:0] ad_in_i,
  output wire req_ready_o,
  output reg bus_clock_output_o,
  output reg [2:0] bus_cycle_status_o,
  output reg ale_o,
  output reg rd_n_o,
  output reg wr_n_o,
  output reg [3:0] upper_address_bits_o,
  output reg [15:0] ad_out_o,
  output reg ad_oe_o,
  output reg [2:0] tstate_o,
  output reg wait_tstate_o,
  output reg idle_tstate_o,
  output reg bus_ready_o,
  output reg [15:0] rdata_o,
  output reg rdata_valid_o,
  output reg queue_load_o
);

  reg phase2_r;
  reg [2:0] ts_r;
  reg [2:0] kind_r;
  reg [ADDR_W-1:0] addr_r;
  reg [15:0] wdata_r;
  reg last_write_r;
  reg ard_m_r;
  reg ard_s_r;
  reg srd_m_r;
  reg srd_s_r;
  reg ard_p2_r;
  reg ard_p1_r;
  reg srd_p1_r;
  wire ready_w;
  wire is_read_w;
  wire is_write_w;
  wire idle_cause_w;
  wire start_w;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops ahead of the ready latches; adds fixed latency only
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ard_m_r <= 1'b0;
      ard_s_r <= 1'b0;
      srd_m_r <= 1'b0;
      srd_s_r <= 1'b0;
    end else if (ce_i) begin
      ard_m_r <= async_ready_in_i;
      ard_s_r <= ard_m_r;
      srd_m_r <= sync_ready_in_i;
      srd_s_r <= srd_m_r;
    end
  end

  // ----------------------------------------
  // Ready latches
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ard_p2_r <= 1'b0;
      ard_p1_r <= 1'b0;
      srd_p1_r <= 1'b0;
    end else if (ce_i) begin
      if (!phase2_r) begin
        ard_p2_r <= ard_s_r;
      end else begin
        ard_p1_r <= ard_s_r & ard_p2_r;
        srd_p1_r <= srd_s_r;
      end
    end
  end

  assign ready_w = ard_p1_r | srd_p1_r;

  assign is_read_w = (kind_r == `ST_IORD) || (kind_r == `ST_FETCH) ||
                     (kind_r == `ST_MEMRD) || (kind_r == `ST_INTA);
  assign is_write_w = (kind_r == `ST_IOWR) || (kind_r == `ST_MEMWR);
  assign idle_cause_w = queue_full_i | ea_calc_i | lock_idle_i | halt_wait_i;
  assign start_w = req_valid_i && !idle_cause_w && (req_status_i != `ST_PASSIVE) &&
                   ((ts_r == `TS_IDLE) || (ts_r == `TS_T4));
  assign req_ready_o = ce_i && phase2_r && start_w;

  // ----------------------------------------
  // T-state sequencer
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase2_r <= 1'b0;
      ts_r <= `TS_IDLE;
      kind_r <= `ST_PASSIVE;
      addr_r <= `ADDR_RST;
      wdata_r <= `DATA_RST;
      last_write_r <= 1'b0;
      bus_clock_output_o <= 1'b0;
      bus_ready_o <= 1'b0;
      wait_tstate_o <= 1'b0;
    end else if (ce_i) begin
      phase2_r <= ~phase2_r;
      bus_clock_output_o <= ~phase2_r;
      if (phase2_r) begin
        wait_tstate_o <= 1'b0;
        case (ts_r)
          `TS_IDLE,
          `TS_T4: begin
            if (start_w) begin
              ts_r <= `TS_T1;
              kind_r <= req_status_i;
              addr_r <= req_addr_i;
              wdata_r <= req_wdata_i;
            end else begin
              if (ts_r == `TS_T4) begin
                last_write_r <= is_write_w;
              end
              ts_r <= `TS_IDLE;
              kind_r <= `ST_PASSIVE;
            end
          end
          `TS_T1: ts_r <= (kind_r == `ST_HALT) ? `TS_IDLE : `TS_T2;
          `TS_T2: ts_r <= `TS_T3;
          `TS_T3: begin
            bus_ready_o <= ready_w;
            if (ready_w) begin
              ts_r <= `TS_T4;
            end else begin
              wait_tstate_o <= 1'b1;
            end
          end
          default: ts_r <= `TS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Bus pins and data capture
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_cycle_status_o <= `ST_PASSIVE;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      upper_address_bits_o <= 4'h0;
      ad_out_o <= `DATA_RST;
      ad_oe_o <= 1'b0;
      tstate_o <= `TS_IDLE;
      idle_tstate_o <= 1'b1;
      rdata_o <= `DATA_RST;
      rdata_valid_o <= 1'b0;
      queue_load_o <= 1'b0;
    end else if (ce_i) begin
      tstate_o <= ts_r;
      idle_tstate_o <= (ts_r == `TS_IDLE);
      rdata_valid_o <= 1'b0;
      queue_load_o <= 1'b0;
      bus_cycle_status_o <= (ts_r == `TS_T1 || ts_r == `TS_T2 || ts_r == `TS_T3) ?
                            kind_r : `ST_PASSIVE;
      ale_o <= (ts_r == `TS_T1) && !phase2_r;
      rd_n_o <= !(is_read_w && kind_r != `ST_INTA &&
                  (ts_r == `TS_T2 || ts_r == `TS_T3));
      wr_n_o <= !(is_write_w && (ts_r == `TS_T2 || ts_r == `TS_T3));
      case (ts_r)
        `TS_T1: begin
          ad_oe_o <= (kind_r != `ST_HALT) && (kind_r != `ST_INTA);
          ad_out_o <= addr_r[15:0];
          if (kind_r == `ST_IORD || kind_r == `ST_IOWR) begin
            upper_address_bits_o <= 4'h0;
          end else begin
            upper_address_bits_o <= addr_r[ADDR_W-1:ADDR_W-4];
          end
        end
        `TS_T2,
        `TS_T3: begin
          ad_oe_o <= is_write_w;
          ad_out_o <= is_write_w ? wdata_r : ad_out_o;
        end
        `TS_T4: begin
          ad_oe_o <= is_write_w;
          if (is_read_w && phase2_r == 1'b0) begin
            rdata_o <= ad_in_i;
            rdata_valid_o <= 1'b1;
            queue_load_o <= (kind_r == `ST_FETCH);
          end
        end
        default: begin
          ad_oe_o <= last_write_r;
        end
      endcase
    end
  end

endmodule

// ===== logic/bus_ready_defs.vh
// Purpose: Constants for the bus ready sampling and idle control block
// Assumes: Included by bus_ready_idle.v only
// Notes: Status codes are the raw bus_cycle_status levels
`ifndef BUS_READY_DEFS_VH
`define BUS_READY_DEFS_VH

// ----------------------------------------
// T-state codes
// ----------------------------------------
`define TS_IDLE 3'h0
`define TS_T1 3'h1
`define TS_T2 3'h2
`define TS_T3 3'h3
`define TS_T4 3'h4

// ----------------------------------------
// Bus cycle status codes
// ----------------------------------------
`define ST_INTA 3'h0
`define ST_IORD 3'h1
`define ST_IOWR 3'h2
`define ST_HALT 3'h3
`define ST_FETCH 3'h4
`define ST_MEMRD 3'h5
`define ST_MEMWR 3'h6
`define ST_PASSIVE 3'h7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define ADDR_W 20
`define PORT_W 16
`define ADDR_RST 20'h00000
`define DATA_RST 16'h0000

`endif

// ===== sim/ready_partner.sv
// Purpose: Ready logic of an external device answering bus cycles
// Assumes: Strobes active low; delay counted in system clocks
// Notes: Zero delay gives a normally ready device
`timescale 1ns/100ps
module ready_partner (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire sel_sync_i,
  input wire [7:0] dly_i,
  output wire async_rdy_o,
  output wire sync_rdy_o
);
  reg [7:0] cnt_r;
  wire rdy;
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      cnt_r <= 8'h00;
    else if (rd_n_i && wr_n_i)
      cnt_r <= 8'h00;
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  end
  assign rdy = cnt_r >= dly_i;
  // Unselected input held inactive
  assign async_rdy_o = rdy && !sel_sync_i;
  assign sync_rdy_o = rdy && sel_sync_i;
endmodule

// ===== sim/bus_ready_idle_chk.sv
// Purpose: Port assertions for the ready and idle block
// Assumes: One clock, asynchronous active-low reset
// Notes: Eight-clock windows cover the ready synchronisers
`timescale 1ns/100ps
module bus_ready_idle_chk (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire ce_i,
  input wire async_ready_in_i,
  input wire sync_ready_in_i,
  input wire req_valid_i,
  input wire [2:0] req_status_i,
  input wire queue_full_i,
  input wire ea_calc_i,
  input wire lock_idle_i,
  input wire halt_wait_i,
  input wire req_ready_o,
  input wire bus_clock_output_o,
  input wire [2:0] bus_cycle_status_o,
  input wire rd_n_o,
  input wire wr_n_o,
  input wire [3:0] upper_address_bits_o,
  input wire [2:0] tstate_o,
  input wire wait_tstate_o,
  input wire idle_tstate_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  idle_no_strobe_a: assert property (idle_tstate_o |-> rd_n_o && wr_n_o)
    else $error("strobe active in idle");
  idle_state_a: assert property (idle_tstate_o |-> tstate_o == 3'h0)
    else $error("idle flag outside idle state");
  wait_in_t3_a: assert property (wait_tstate_o |-> tstate_o == 3'h3)
    else $error("wait state not a repeated T3");
  io_upper_zero_a: assert property (!rd_n_o && bus_cycle_status_o == 3'h1
    |-> upper_address_bits_o == 4'h0) else $error("upper bits set on io read");
  accept_gate_a: assert property (req_ready_o |-> req_valid_i && req_status_i != 3'h7
    && !(queue_full_i || ea_calc_i || lock_idle_i || halt_wait_i)) else $error("bad accept");
  clk_toggle_a: assert property ($past(ce_i) && $past(nrst_i)
    |-> bus_clock_output_o != $past(bus_clock_output_o)) else $error("bus clock stuck");
  tstate_two_a: assert property (ce_i && $changed(tstate_o) |=> $stable(tstate_o))
    else $error("T-state not two clocks");
  async_nowait_a: assert property (async_ready_in_i [*8] |=> !$rose(wait_tstate_o))
    else $error("wait despite async ready");
  sync_nowait_a: assert property (sync_ready_in_i [*8] |=> !$rose(wait_tstate_o))
    else $error("wait despite sync ready");
endmodule
bind bus_ready_idle bus_ready_idle_chk u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .async_ready_in_i(async_ready_in_i), .sync_ready_in_i(sync_ready_in_i),
  .req_valid_i(req_valid_i), .req_status_i(req_status_i), .queue_full_i(queue_full_i),
  .ea_calc_i(ea_calc_i), .lock_idle_i(lock_idle_i), .halt_wait_i(halt_wait_i),
  .req_ready_o(req_ready_o), .bus_clock_output_o(bus_clock_output_o),
  .bus_cycle_status_o(bus_cycle_status_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
  .upper_address_bits_o(upper_address_bits_o), .tstate_o(tstate_o),
  .wait_tstate_o(wait_tstate_o), .idle_tstate_o(idle_tstate_o));

// ===== sim/tb.sv
// Purpose: Self-checking bench for the ready and idle block
// Assumes: Inputs change on the falling clock edge
// Notes: Wait counts are judged as zero or nonzero only
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h seen %h", n, e, a); end end
module tb;
  reg clk_sys_i = 0, nrst_i = 0, req_valid_i = 0, sel = 0, seen;
  reg [2:0] req_status_i = 3'h7;
  reg [19:0] req_addr_i = 20'h00000;
  reg [3:0] cause = 4'h0;
  reg [7:0] dly = 8'h00;
  reg [32:0] rows [0:5];
  integer err_count = 0, checked = 0, k;
  wire ar, sr, rdy, ck, ale, rd_n, wr_n, oe, wt, idl, rv, ql, brd;
  wire [2:0] st, ts;
  wire [3:0] up;
  wire [15:0] rd, ado;
  bus_ready_idle u_bus_ready_idle (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .async_ready_in_i(ar), .sync_ready_in_i(sr), .req_valid_i(req_valid_i),
    .req_status_i(req_status_i), .req_addr_i(req_addr_i), .req_wdata_i(16'h5aa5),
    .queue_full_i(cause[0]), .ea_calc_i(cause[1]), .lock_idle_i(cause[2]),
    .halt_wait_i(cause[3]), .ad_in_i(16'hc3a5), .req_ready_o(rdy),
    .bus_clock_output_o(ck), .bus_cycle_status_o(st), .ale_o(ale), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .upper_address_bits_o(up), .ad_out_o(ado), .ad_oe_o(oe), .tstate_o(ts),
    .wait_tstate_o(wt), .idle_tstate_o(idl), .bus_ready_o(brd), .rdata_o(rd),
    .rdata_valid_o(rv), .queue_load_o(ql));
  ready_partner u_ready_partner (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .sel_sync_i(sel), .dly_i(dly), .async_rdy_o(ar), .sync_rdy_o(sr));
  always #5 clk_sys_i = ~clk_sys_i;
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      nrst_i = 0;
      repeat (12) @(negedge clk_sys_i);
      `CHK("reset", 12'hf82, {st, rd_n, wr_n, ale, oe, ts, idl, ck})
      nrst_i = 1;
      $display("reset test done");
    end
  endtask
  task run(input [32:0] r);
    integer i, w, q, n;
    reg [3:0] u;
    reg [2:0] s;
    reg [15:0] d, aw;
    begin
      {req_status_i, req_addr_i, sel, dly} = r[32:1];
      req_valid_i = 1;
      d = 16'h0000;
      aw = 16'h0000;
      s = 3'h7;
      // Accept term is combinational; let it settle before reading
      #1;
      for (i = 0; rdy !== 1'b1 && i < 20; i++)
        @(negedge clk_sys_i);
      `CHK("accept", 1'b1, rdy)
      @(negedge clk_sys_i);
      req_valid_i = 0;
      w = 0; q = 0; n = 0;
      for (i = 0; i < 150 && n < 3; i++) begin
        if (wt) w++;
        if (ql) q++;
        if (rv) d = rd;
        if (!rd_n || !wr_n) begin
          u = up;
          s = st;
        end
        if (ale) aw = ado;
        n = (idl && i > 4) ? n + 1 : 0;
        @(negedge clk_sys_i);
      end
      `CHK("finish", 1'b1, n == 3)
      `CHK("waits", r[0], w != 0)
      `CHK("status", req_status_i, s)
      `CHK("address", req_addr_i[15:0], aw)
      `CHK("ready", 1'b1, brd)
      `CHK("upper", req_status_i == 3'h1 ? 4'h0 : req_addr_i[19:16], u)
      `CHK("queue", req_status_i == 3'h4, q == 1)
      if (!req_status_i[1])
        `CHK("rdata", 16'hc3a5, d)
      `CHK("ad_oe", req_status_i[1], oe)
      `CHK("strobes", 2'b11, {rd_n, wr_n})
      $display("cycle test done status %h", req_status_i);
    end
  endtask
  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end
  initial begin
    rows[0] = {3'h5, 20'hab123, 1'b0, 8'h00, 1'b0};
    rows[1] = {3'h1, 20'hf1234, 1'b1, 8'h00, 1'b0};
    rows[2] = {3'h4, 20'h71000, 1'b0, 8'h00, 1'b0};
    rows[3] = {3'h6, 20'h9c00e, 1'b1, 8'h00, 1'b0};
    rows[4] = {3'h5, 20'h30002, 1'b0, 8'h1e, 1'b1};
    rows[5] = {3'h1, 20'hd0040, 1'b1, 8'h1e, 1'b1};
    do_reset;
    for (k = 0; k < 6; k++)
      run(rows[k]);
    for (k = 0; k < 5; k++) begin
      cause = k < 4 ? 4'h1 << k : 4'h0;
      req_status_i = k < 4 ? 3'h5 : 3'h7;
      req_valid_i = 1;
      seen = 0;
      repeat (10) begin
        @(negedge clk_sys_i);
        seen = seen | rdy;
      end
      `CHK("refused", 1'b0, seen)
      `CHK("idle", 1'b1, idl)
      req_valid_i = 0;
      cause = 4'h0;
      @(negedge clk_sys_i);
      $display("idle cause test done %0d", k);
    end
    req_status_i = 3'h5;
    req_valid_i = 1;
    repeat (5) @(negedge clk_sys_i);
    req_valid_i = 0;
    do_reset;
    run(rows[4]);
    report_and_stop;
  end
endmodule
